/* design/cfg_set_ctrl.sv */
// Purpose: Configuration set manager with store, recall, startup load and soft restart
// Assumes: APB slave, single clock, acquiring input synchronous to ref_clk
// Notes:   Copies move one word per cycle between working set and slots
//
// Overview of operation
// [RULE1] The working set lives in volatile storage and is cleared by every reset.
// [RULE2] The factory set is fixed in non-volatile storage and cannot be written.
// [RULE3] Three user slots numbered one to three keep their contents across reset.
// [RULE4] Luminance table entries are never saved into a user slot.
// [RULE5] After power-on and every reset the startup set is copied into the working set.
// [RULE6] Writing one to the store trigger copies the working set into the selected slot.
// [RULE7] A store overwrites every word that the selected slot held.
// [RULE8] Writing one to the recall trigger copies the selected set into the working set.
// [RULE9] Recalled values drive the operating outputs as soon as the copy is done.
// [RULE10] A recall is accepted only while the camera is not acquiring lines.
// [RULE11] The startup selector takes the factory set or user slots one to three.
// [RULE12] A soft restart clears volatile settings, keeps power, then reloads startup set.
// [RULE13] After a soft restart the host waits for the camera to reappear before access.
// [RULE14] Encoding zero is the factory set; a store with zero selected is ignored.
`timescale 1ns/1ps
module cfg_set_ctrl
  import cfg_set_pkg::*;
#(
  parameter int WORDS    = 8,
  parameter int LUT_SIZE = 4
)
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // APB slave
  input  wire apb_req_t            apb_req,
  output      apb_rsp_t            apb_rsp,
  // Camera state
  input  wire logic                acquiring,
  // Working parameters and status
  output      logic [WORDS*32-1:0] active_params,
  output      logic [LUT_SIZE*32-1:0] lut_params,
  output      logic                cfg_ready,
  output      logic                soft_restart_command
);

  localparam int AW = (WORDS > 1) ? $clog2(WORDS) : 1;
  localparam int LW = (LUT_SIZE > 1) ? $clog2(LUT_SIZE) : 1;

  // Elaboration checks on the parameters
  if (WORDS < 1 || WORDS > 256)
  begin : g_bad_words
    $error("cfg_set_ctrl: WORDS out of range");
  end
  if (LUT_SIZE < 1 || LUT_SIZE > 256)
  begin : g_bad_lut
    $error("cfg_set_ctrl: LUT_SIZE out of range");
  end

  ctl_state_t      state_r;
  copy_op_t        op_r;
  logic [1:0]      copy_slot_r;
  logic [AW-1:0]   copy_idx_r;
  logic [1:0]      slot_sel_r;
  logic [1:0]      startup_sel_r;
  logic [AW-1:0]   param_idx_r;
  logic [LW-1:0]   lut_idx_r;
  logic            refused_r;
  logic            ignored_r;
  logic [7:0]      restart_cnt_r;
  logic            active_wr;
  logic [AW-1:0]   active_addr;
  logic [31:0]     active_din;
  logic            active_clear;
  logic [1:0]      nv_slot;
  logic [AW-1:0]   nv_addr;
  logic            nv_wr;
  logic [31:0]     nv_rdata;
  logic [WORDS*32-1:0] set_flat;
  logic [LUT_SIZE*32-1:0] lut_r;
  logic            wr_acc;
  logic            sw_param_wr;
  logic            store_req;
  logic            recall_req;
  logic            restart_req;
  logic            idle;

  // Decode of one register address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_acc = clk_en && apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign idle   = (state_r == st_idle);

  // [RULE6] store trigger
  assign store_req   = wr_acc && hit(apb_req.paddr, ctrl_off) && apb_req.pwdata[store_bit];
  // [RULE8] recall trigger
  assign recall_req  = wr_acc && hit(apb_req.paddr, ctrl_off) && apb_req.pwdata[recall_bit]
                       && !apb_req.pwdata[store_bit];
  assign restart_req = wr_acc && hit(apb_req.paddr, ctrl_off) && apb_req.pwdata[restart_bit];
  assign sw_param_wr = wr_acc && idle && hit(apb_req.paddr, param_data_off);

  // Working set write source
  always_comb
  begin
    active_wr    = 1'b0;
    active_addr  = param_idx_r;
    active_din   = apb_req.pwdata;
    active_clear = (state_r == st_restart);
    if (state_r == st_copy && op_r == op_load)
    begin
      active_wr   = 1'b1;
      active_addr = copy_idx_r;
      active_din  = nv_rdata;
    end
    else if (sw_param_wr)
      active_wr = 1'b1;
  end

  // Slot storage access
  always_comb
  begin
    nv_slot = copy_slot_r;
    nv_addr = copy_idx_r;
    // [RULE7] every word rewritten
    nv_wr   = (state_r == st_copy) && (op_r == op_store);
  end

  cfg_active_set #(
    .WORDS (WORDS),
    .DW    (32),
    .AW    (AW)
  ) u_active (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .clear    (active_clear),
    .wr_en    (active_wr),
    .wr_addr  (active_addr),
    .wr_data  (active_din),
    .set_flat (set_flat)
  );

  // [RULE4] table kept out of saves
  cfg_nv_store #(
    .WORDS (WORDS),
    .DW    (32),
    .AW    (AW)
  ) u_nv (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .slot    (nv_slot),
    .addr    (nv_addr),
    .wr_en   (nv_wr),
    .wr_data (set_flat[32*32'(copy_idx_r) +: 32]),
    .rd_data (nv_rdata)
  );

  // Control state machine
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r       <= st_boot;
      op_r          <= op_none;
      copy_slot_r   <= startup_rst;
      copy_idx_r    <= '0;
      restart_cnt_r <= '0;
      refused_r     <= 1'b0;
      ignored_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state_r)
        st_boot:
        begin
          // [RULE5] load startup set
          state_r     <= st_copy;
          op_r        <= op_load;
          copy_slot_r <= startup_sel_r;
          copy_idx_r  <= '0;
        end
        st_copy:
        begin
          if (copy_idx_r == AW'(WORDS - 1))
          begin
            state_r <= st_idle;
            op_r    <= op_none;
          end
          else
            copy_idx_r <= copy_idx_r + 1'b1;
        end
        st_idle:
        begin
          if (restart_req)
          begin
            // [RULE12] soft restart
            state_r       <= st_restart;
            restart_cnt_r <= '0;
          end
          else if (store_req)
          begin
            // [RULE14] store to default ignored
            if (slot_sel_r == slot_default)
              ignored_r <= 1'b1;
            else
            begin
              state_r     <= st_copy;
              op_r        <= op_store;
              copy_slot_r <= slot_sel_r;
              copy_idx_r  <= '0;
              ignored_r   <= 1'b0;
            end
          end
          else if (recall_req)
          begin
            // [RULE10] recall only when idle
            if (acquiring)
              refused_r <= 1'b1;
            else
            begin
              // [RULE9] recalled values take over
              state_r     <= st_copy;
              op_r        <= op_load;
              copy_slot_r <= slot_sel_r;
              copy_idx_r  <= '0;
              refused_r   <= 1'b0;
            end
          end
        end
        st_restart:
        begin
          if (restart_cnt_r == 8'(restart_cycles - 1))
          begin
            state_r   <= st_boot;
            refused_r <= 1'b0;
            ignored_r <= 1'b0;
          end
          else
            restart_cnt_r <= restart_cnt_r + 8'h01;
        end
        default:
          state_r <= st_boot;
      endcase
    end
  end

  // Selectors and index registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_sel_r    <= slot_sel_rst;
      startup_sel_r <= startup_rst;
      param_idx_r   <= '0;
      lut_idx_r     <= '0;
    end
    // [RULE12] slot selector and index registers dropped, startup selector kept
    else if (clk_en && state_r == st_restart)
    begin
      slot_sel_r  <= slot_sel_rst;
      param_idx_r <= '0;
      lut_idx_r   <= '0;
    end
    else if (clk_en && idle && wr_acc)
    begin
      if (hit(apb_req.paddr, slot_sel_off))
        slot_sel_r <= apb_req.pwdata[1:0];
      // [RULE11] startup selector
      else if (hit(apb_req.paddr, startup_sel_off))
        startup_sel_r <= apb_req.pwdata[1:0];
      else if (hit(apb_req.paddr, param_idx_off))
        param_idx_r <= apb_req.pwdata[AW-1:0];
      else if (hit(apb_req.paddr, lut_idx_off))
        lut_idx_r <= apb_req.pwdata[LW-1:0];
    end
  end

  // [RULE4] volatile table, lost on restart
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lut_r <= '0;
    else if (clk_en)
    begin
      if (state_r == st_restart)
        lut_r <= '0;
      else if (wr_acc && idle && hit(apb_req.paddr, lut_data_off))
        lut_r[32*32'(lut_idx_r) +: 32] <= apb_req.pwdata;
    end
  end

  // APB answer, wait state free
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      apb_rsp <= '0;
    else if (clk_en)
    begin
      apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.prdata  <= '0;
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      begin
        if (hit(apb_req.paddr, status_off))
          apb_rsp.prdata <= {27'h0, state_r == st_restart, acquiring, ignored_r,
                             refused_r, !idle};
        else if (hit(apb_req.paddr, slot_sel_off))
          apb_rsp.prdata <= {30'h0, slot_sel_r};
        else if (hit(apb_req.paddr, startup_sel_off))
          apb_rsp.prdata <= {30'h0, startup_sel_r};
        else if (hit(apb_req.paddr, param_idx_off))
          apb_rsp.prdata <= 32'(param_idx_r);
        else if (hit(apb_req.paddr, param_data_off))
          apb_rsp.prdata <= set_flat[32*32'(param_idx_r) +: 32];
        else if (hit(apb_req.paddr, lut_idx_off))
          apb_rsp.prdata <= 32'(lut_idx_r);
        else if (hit(apb_req.paddr, lut_data_off))
          apb_rsp.prdata <= lut_r[32*32'(lut_idx_r) +: 32];
        else if (!hit(apb_req.paddr, ctrl_off))
          apb_rsp.pslverr <= 1'b1;
      end
      else if (apb_req.psel && !apb_req.penable)
      begin
        if (!(hit(apb_req.paddr, ctrl_off) || hit(apb_req.paddr, slot_sel_off)
              || hit(apb_req.paddr, startup_sel_off) || hit(apb_req.paddr, param_idx_off)
              || hit(apb_req.paddr, param_data_off) || hit(apb_req.paddr, lut_idx_off)
              || hit(apb_req.paddr, lut_data_off)))
          apb_rsp.pslverr <= 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_params        <= '0;
      lut_params           <= '0;
      cfg_ready            <= 1'b0;
      soft_restart_command <= 1'b0;
    end
    else if (clk_en)
    begin
      // [RULE9] working set drives operation
      active_params        <= set_flat;
      lut_params           <= lut_r;
      cfg_ready            <= idle;
      // [RULE13] host sees device gone
      soft_restart_command <= (state_r == st_restart);
    end
  end

endmodule : cfg_set_ctrl

/* design/cfg_set_pkg.sv */
// Purpose: Shared constants and types for the configuration set store and recall block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Slot encoding: 0 factory default, 1..3 user slots
package cfg_set_pkg;

  // Register byte offsets
  localparam logic [7:0] ctrl_off       = 8'h00;
  localparam logic [7:0] status_off     = 8'h04;
  localparam logic [7:0] slot_sel_off   = 8'h08;
  localparam logic [7:0] startup_sel_off = 8'h0c;
  localparam logic [7:0] param_idx_off  = 8'h10;
  localparam logic [7:0] param_data_off = 8'h14;
  localparam logic [7:0] lut_idx_off    = 8'h18;
  localparam logic [7:0] lut_data_off   = 8'h1c;

  // Control register fields (write one to trigger)
  localparam int store_bit   = 0;
  localparam int recall_bit  = 1;
  localparam int restart_bit = 2;

  // Status register fields
  localparam int busy_bit      = 0;
  localparam int refused_bit   = 1;
  localparam int ignored_bit   = 2;
  localparam int acq_bit       = 3;
  localparam int restarting_bit = 4;

  // Slot encodings and reset values
  localparam logic [1:0] slot_default = 2'h0;
  localparam logic [1:0] slot_user1   = 2'h1;
  localparam logic [1:0] slot_sel_rst = 2'h1;
  localparam logic [1:0] startup_rst  = 2'h0;

  // Software restart hold time in cycles
  localparam int restart_cycles = 16;

  typedef enum logic [2:0] {
    st_boot    = 3'b000,
    st_copy    = 3'b001,
    st_idle    = 3'b010,
    st_restart = 3'b011
  } ctl_state_t;

  typedef enum logic [1:0] {
    op_load  = 2'b00,
    op_store = 2'b01,
    op_none  = 2'b10
  } copy_op_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : cfg_set_pkg

/* design/cfg_nv_store.sv */
// Purpose: Non-volatile slot storage: one read-only factory set and three user slots
// Assumes: Contents survive reset; factory set is fixed by parameter
// Notes:   Writes to slot zero are dropped
`timescale 1ns/1ps
module cfg_nv_store
  import cfg_set_pkg::*;
#(
  parameter int WORDS   = 8,
  parameter int DW      = 32,
  parameter int AW      = 3,
  parameter logic [DW-1:0] FACTORY_BASE = 32'h0000_1000
)
(
  // Clock
  input  wire logic          ref_clk,
  input  wire logic          clk_en,
  // Access
  input  wire logic [1:0]    slot,
  input  wire logic [AW-1:0] addr,
  input  wire logic          wr_en,
  input  wire logic [DW-1:0] wr_data,
  output      logic [DW-1:0] rd_data
);

  // Elaboration check on the address width
  if ((1 << AW) < WORDS)
  begin : g_bad_aw
    $error("cfg_nv_store: AW too small for WORDS");
  end

  // Three user slots, no reset so contents persist
  logic [DW-1:0] user_mem [0:3*WORDS-1];

  // Factory set generated as constants
  function automatic logic [DW-1:0] factory_word(input logic [AW-1:0] a);
    factory_word = FACTORY_BASE + DW'(a);
  endfunction : factory_word

  // [RULE3] three user slots
  always_ff @(posedge ref_clk)
  begin
    // [RULE2] factory set read only
    if (clk_en && wr_en && slot != slot_default)
      user_mem[(32'(slot) - 1) * WORDS + 32'(addr)] <= wr_data;
  end

  always_comb
  begin
    if (slot == slot_default)
      rd_data = factory_word(addr);
    else
      rd_data = user_mem[(32'(slot) - 1) * WORDS + 32'(addr)];
  end

endmodule : cfg_nv_store

/* design/cfg_active_set.sv */
// Purpose: Volatile working parameter set
// Assumes: Cleared by any reset or software restart
// Notes:   Single write port, flat output
`timescale 1ns/1ps
module cfg_active_set
  import cfg_set_pkg::*;
#(
  parameter int WORDS = 8,
  parameter int DW    = 32,
  parameter int AW    = 3
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              clear,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [DW-1:0]     wr_data,
  // Contents
  output      logic [WORDS*DW-1:0] set_flat
);

  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_word
      // [RULE1] volatile, lost on reset
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          set_flat[g*DW +: DW] <= '0;
        else if (clk_en)
        begin
          if (clear)
            set_flat[g*DW +: DW] <= '0;
          else if (wr_en && wr_addr == AW'(g))
            set_flat[g*DW +: DW] <= wr_data;
        end
      end
    end
  endgenerate

endmodule : cfg_active_set

/* sim/cfg_set_ctrl_assertions.sv */
// Purpose: Port checker for the configuration set manager
// Assumes: clk_en held high; selector writes tracked from the bus
// Notes:   Bound to cfg_set_ctrl after the module
`timescale 1ns/1ps
module cfg_set_ctrl_chk
  import cfg_set_pkg::*;
#(
  parameter int WORDS    = 8,
  parameter int LUT_SIZE = 4
)
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  // Bus
  input wire apb_req_t               apb_req,
  input wire apb_rsp_t               apb_rsp,
  // Camera and outputs
  input wire logic                   acquiring,
  input wire logic [WORDS*32-1:0]    active_params,
  input wire logic [LUT_SIZE*32-1:0] lut_params,
  input wire logic                   cfg_ready,
  input wire logic                   soft_restart_command
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       acc;
  logic       ctl_wr;
  logic       rs_wr;
  logic       st_wr;
  logic       rc_wr;
  logic [1:0] sel_r;
  assign acc = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready && cfg_ready;
  assign ctl_wr = acc && apb_req.paddr == ctrl_off;
  assign rs_wr = ctl_wr && apb_req.pwdata[restart_bit];
  assign st_wr = ctl_wr && apb_req.pwdata[store_bit] && !rs_wr;
  assign rc_wr = ctl_wr && apb_req.pwdata[recall_bit] && !apb_req.pwdata[store_bit] && !rs_wr;
  // Selector shadow
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sel_r <= slot_sel_rst;
    else if (soft_restart_command)
      sel_r <= slot_sel_rst;
    else if (acc && apb_req.paddr == slot_sel_off)
      sel_r <= apb_req.pwdata[1:0];
  AST_BOOT_LOAD: assert property ($rose(rst_n) |-> !cfg_ready [*8] ##[1:12] cfg_ready)
    else $error("startup load timing wrong");
  AST_SET_HOLDS: assert property (
    cfg_ready && !apb_req.psel ##1 cfg_ready && !apb_req.psel
    |=> $stable(active_params) && $stable(lut_params))
    else $error("working set changed unasked");
  AST_RECALL_ACQ: assert property (rc_wr && acquiring |=> cfg_ready [*3])
    else $error("recall taken while acquiring");
  AST_RECALL_RUN: assert property (rc_wr && !acquiring |->
    ##[1:2] !cfg_ready ##[1:12] cfg_ready)
    else $error("recall copy missing");
  AST_STORE_DFLT: assert property (st_wr && sel_r == slot_default |=> cfg_ready [*3])
    else $error("store to factory set not ignored");
  AST_STORE_RUN: assert property (st_wr && sel_r != slot_default |->
    ##[1:2] !cfg_ready ##[1:12] cfg_ready)
    else $error("store copy missing");
  AST_STORE_KEEP: assert property (st_wr |=> $stable(active_params) [*8])
    else $error("store altered working set");
  AST_RESTART: assert property (rs_wr |->
    ##[1:2] soft_restart_command [*8] ##[1:40] cfg_ready)
    else $error("soft restart sequence wrong");
  AST_RESTART_CLR: assert property (soft_restart_command [*3] |->
    !cfg_ready && active_params == '0 && lut_params == '0)
    else $error("volatile settings kept in restart");
  AST_APB_READY: assert property (apb_req.psel && !apb_req.penable && clk_en |=> apb_rsp.pready)
    else $error("access phase not answered");
endmodule : cfg_set_ctrl_chk

bind cfg_set_ctrl cfg_set_ctrl_chk #(.WORDS(WORDS), .LUT_SIZE(LUT_SIZE)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .acquiring(acquiring), .active_params(active_params), .lut_params(lut_params),
  .cfg_ready(cfg_ready), .soft_restart_command(soft_restart_command));

/* sim/cfg_set_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the configuration set manager
// Assumes: Factory word i is 0x1000 plus i
// Notes:   Random parameter values from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected %s exp=%h got=%h", nm, e, g); \
    end \
  end
module cfg_set_ctrl_tb_top
  import cfg_set_pkg::*;
;
  localparam int W = 8;
  localparam int L = 4;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            acquiring = 1'b0;
  apb_req_t        req = '0;
  apb_rsp_t        rsp;
  logic [W*32-1:0] act;
  logic [L*32-1:0] lut;
  logic            cfg_ready;
  logic            restarting;
  logic [31:0]     act_exp [W];
  logic [31:0]     lut_exp [L];
  logic [31:0]     slot_exp [4][W];
  logic [31:0]     rd;
  logic            err;
  integer          seed = 32'hdb50dff9;
  int              n_fail = 0;
  int              total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  cfg_set_ctrl #(.WORDS(W), .LUT_SIZE(L)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .acquiring(acquiring), .active_params(act),
    .lut_params(lut), .cfg_ready(cfg_ready), .soft_restart_command(restarting));
  function automatic logic [31:0] factory_word(input int i);
    return 32'h0000_1000 + 32'(i);
  endfunction : factory_word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    repeat (2) @(posedge ref_clk);
    while (cfg_ready !== 1'b1)
      @(posedge ref_clk);
  endtask : wait_idle
  task automatic op(input int b);
    apb(1'b1, ctrl_off, 32'h1 << b);
    wait_idle();
  endtask : op
  task automatic load_rand();
    for (int i = 0; i < W; i++)
    begin
      act_exp[i] = $random(seed);
      apb(1'b1, param_idx_off, 32'(i));
      apb(1'b1, param_data_off, act_exp[i]);
    end
    for (int i = 0; i < L; i++)
    begin
      lut_exp[i] = $random(seed);
      apb(1'b1, lut_idx_off, 32'(i));
      apb(1'b1, lut_data_off, lut_exp[i]);
    end
    repeat (2) @(posedge ref_clk);
  endtask : load_rand
  task automatic check_set();
    for (int i = 0; i < W; i++)
      `CHK("active word", act_exp[i], act[32*i+:32])
    for (int i = 0; i < L; i++)
      `CHK("lut word", lut_exp[i], lut[32*i+:32])
  endtask : check_set
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    for (int i = 0; i < W; i++) slot_exp[0][i] = factory_word(i);
    foreach (lut_exp[i]) lut_exp[i] = '0;
    repeat (3) @(posedge ref_clk);
    `CHK("reset set", '0, act)
    rst_n <= 1'b1;
    wait_idle();
    act_exp = slot_exp[0];
    check_set();
    apb(1'b0, slot_sel_off, '0);
    `CHK("slot_sel", {30'h0, slot_sel_rst}, rd)
    apb(1'b0, startup_sel_off, '0);
    `CHK("startup_sel", {30'h0, startup_rst}, rd)
    apb(1'b0, 8'h40, '0);
    `CHK("pslverr", 1'b1, err)
    $display("test reset done");
    for (int s = 1; s <= 4; s++)
    begin
      load_rand();
      apb(1'b1, slot_sel_off, (s == 4) ? 32'h2 : 32'(s));
      op(store_bit);
      slot_exp[(s == 4) ? 2 : s] = act_exp;
    end
    load_rand();
    for (int s = 3; s >= 1; s--)
    begin
      apb(1'b1, slot_sel_off, 32'(s));
      op(recall_bit);
      act_exp = slot_exp[s];
      check_set();
    end
    $display("test store recall done");
    apb(1'b1, slot_sel_off, '0);
    op(store_bit);
    apb(1'b0, status_off, '0);
    `CHK("store ignored", 1'b1, rd[ignored_bit])
    op(recall_bit);
    act_exp = slot_exp[0];
    check_set();
    apb(1'b1, slot_sel_off, 32'h1);
    acquiring <= 1'b1;
    op(recall_bit);
    apb(1'b0, status_off, '0);
    `CHK("recall refused", 2'b11, {rd[acq_bit], rd[refused_bit]})
    check_set();
    acquiring <= 1'b0;
    op(recall_bit);
    act_exp = slot_exp[1];
    check_set();
    apb(1'b0, param_data_off, '0);
    `CHK("param read", slot_exp[1][W-1], rd)
    $display("test default and acquire done");
    foreach (lut_exp[i]) lut_exp[i] = '0;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, startup_sel_off, 32'(s));
      apb(1'b1, ctrl_off, 32'h1 << restart_bit);
      apb(1'b0, status_off, '0);
      `CHK("restart status", 2'b11, {rd[restarting_bit], rd[busy_bit]})
      `CHK("restart pin", 1'b1, restarting)
      wait_idle();
      act_exp = slot_exp[s];
      check_set();
    end
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_idle();
    act_exp = slot_exp[0];
    check_set();
    apb(1'b1, slot_sel_off, 32'h2);
    op(recall_bit);
    act_exp = slot_exp[2];
    check_set();
    $display("test restart done");
    tally_and_finish();
  end
endmodule : cfg_set_ctrl_tb_top
